// ==== hdl/cap2_regs_pkg.sv ====
// Package: offsets, field positions, reset values and carriers of the bank
package cap2_regs_pkg;

  // ----------------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] DEV_CAP2_OFF    = 8'hE4;
  localparam logic [7:0] DEV_CTL2_OFF    = 8'hE8;  // Control low, status high
  localparam logic [7:0] LINK_CAP2_OFF   = 8'hEC;
  localparam logic [7:0] LINK_CTL2_OFF   = 8'hF0;  // Control low, status high
  localparam logic [7:0] SLOT_CAP2_OFF   = 8'hF4;
  localparam logic [7:0] SLOT_CTL2_OFF   = 8'hF8;  // Control low, status high
  localparam logic [7:0] SLOT_CTLSTS_OFF = 8'hD8;  // Slot control and status

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int DEVCAP2_LTR_BIT   = 11;
  localparam int DEVCAP2_OBFF_LSB  = 18;
  localparam int DEVCTL2_LTR_BIT   = 10;
  localparam int DEVCTL2_OBFF_LSB  = 13;
  localparam int LCTL2_SPEED_LSB   = 0;
  localparam int LCTL2_ENTCOMP_BIT = 4;
  localparam int LCTL2_HWDIS_BIT   = 5;
  localparam int LCTL2_SELDE_BIT   = 6;
  localparam int LCTL2_MARGIN_LSB  = 7;
  localparam int LCTL2_MODCOMP_BIT = 10;
  localparam int LCTL2_SOS_BIT     = 11;
  localparam int LCTL2_COMPDE_BIT  = 12;
  localparam int LSTS2_DELVL_BIT   = 16;
  localparam int SLOTSTS_DLLSC_BIT = 24;

  // ----------------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  OBFF_SUPPORT_VAL = 2'h1;
  localparam logic [31:0] DEV_CAP2_VAL     =
    (32'h0000_0001 << DEVCAP2_LTR_BIT) |
    ({30'h0000_0000, OBFF_SUPPORT_VAL} << DEVCAP2_OBFF_LSB);
  localparam logic [3:0]  SPEED_RST_VAL    = 4'h2;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] obff_en;
    logic       ltr_en;
  } dev_ctl2_type;

  typedef struct packed {
    logic       compliance_deemph;
    logic       compliance_sos;
    logic       enter_mod_compliance;
    logic [2:0] tx_margin;
    logic       hw_autospeed_dis;
    logic       enter_compliance;
    logic [3:0] target_speed;
  } link_ctl2_type;

  localparam dev_ctl2_type  DEV_CTL2_RST  = '{obff_en: 2'h0, ltr_en: 1'b0};
  localparam link_ctl2_type LINK_CTL2_RST = '{
    compliance_deemph: 1'b0, compliance_sos: 1'b0,
    enter_mod_compliance: 1'b0, tx_margin: 3'h0, hw_autospeed_dis: 1'b0,
    enter_compliance: 1'b0, target_speed: SPEED_RST_VAL};

endpackage

// ==== hdl/link_active_watch.sv ====
// Synchroniser and change detector for the link-active indication
`timescale 1ns/1ps
module link_active_watch (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic active_in,
  output logic      active_level,
  output logic      active_changed
);

  // ----------------------------------------------------------------------
  // Three-stage sampling
  // ----------------------------------------------------------------------
  logic meta_ff;
  logic sync_a_ff;
  logic sync_b_ff;
  logic level_ff;
  logic changed_ff;
  logic agree;

  // First stage feeds only the second; agreement of stages two and three
  // filters a single-cycle glitch that slipped through
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff   <= 1'b0;
      sync_a_ff <= 1'b0;
      sync_b_ff <= 1'b0;
    end else begin
      meta_ff   <= active_in;
      sync_a_ff <= meta_ff;
      sync_b_ff <= sync_a_ff;
    end
  end

  assign agree = (sync_a_ff == sync_b_ff);

  // Accepted level and one-cycle change pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_ff   <= 1'b0;
      changed_ff <= 1'b0;
    end else begin
      changed_ff <= agree && (sync_b_ff != level_ff);
      if (agree) begin
        level_ff <= sync_b_ff;
      end
    end
  end

  assign active_level   = level_ff;
  assign active_changed = changed_ff;

endmodule // link_active_watch

// ==== hdl/cap2_regs.sv ====
// Second-generation capability register bank with an AXI4-Lite slave
//
// Function
// - Device capabilities 2 bit 11 reads constant 1, LTR supported.
// - Device capabilities 2 bits 19:18 read constant 01, OBFF supported.
// - Device control 2 LTR enable bit 10, OBFF enable 14:13, reset zero.
// - Upstream port: de-emphasis select and current level read 0.
// - Downstream ports: de-emphasis select and current level read 1.
// - Link-active change sets slot status bit 24; write 1 clears it.
`timescale 1ns/1ps
module cap2_regs
  import cap2_regs_pkg::*;
#(
  parameter int ADDR_WIDTH    = 8,
  parameter bit IS_DOWNSTREAM = 1'b0
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  conv_rst_n,
  input  wire logic                  dl_link_active,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output dev_ctl2_type               dev_ctl2,
  output link_ctl2_type              link_ctl2,
  output logic                       dll_state_changed
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr
    $error("ADDR_WIDTH must lie between 8 and 32");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                  aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff, rd_fire;
  logic [ADDR_WIDTH-1:0] awaddr_ff, wr_word, rd_word;
  logic [31:0]           wdata_ff, rdata_ff, rd_value, byte_mask;
  logic [3:0]            wstrb_ff;
  logic [1:0]            bresp_ff, rresp_ff;
  dev_ctl2_type          dev_ctl2_ff, nxt_dev_ctl2;
  link_ctl2_type         link_ctl2_ff, nxt_link_ctl2;
  logic                  dllsc_ff, nxt_dllsc, link_chg, deemph, rd_hit;
  logic [31:0]           dev_ctl2_img, link_ctl2_img, slot_sts_img;
  logic [31:0]           dev_ctl2_merged, link_ctl2_merged;
  logic                  wr_fire, wr_hit, wr_devctl, wr_linkctl, wr_slotsts;

  // Port role fixes the de-emphasis default
  assign deemph = IS_DOWNSTREAM;

  // ----------------------------------------------------------------------
  // Link-active change detection
  // ----------------------------------------------------------------------
  link_active_watch u_watch (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .active_in      (dl_link_active),
    .active_level   (),
    .active_changed (link_chg)
  );

  // ----------------------------------------------------------------------
  // Write channel: address and data are taken in either order
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready  = !w_held_ff;
  assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;

  // Hold address and data until both are present and no response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= ZERO_WORD;
      wstrb_ff   <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Word-aligned decode; low address bits are ignored
  assign wr_word    = {awaddr_ff[ADDR_WIDTH-1:2], 2'h0};
  assign wr_devctl  = wr_fire && (wr_word == ADDR_WIDTH'(DEV_CTL2_OFF));
  assign wr_linkctl = wr_fire && (wr_word == ADDR_WIDTH'(LINK_CTL2_OFF));
  assign wr_slotsts = wr_fire && (wr_word == ADDR_WIDTH'(SLOT_CTLSTS_OFF));
  assign wr_hit     = (wr_word == ADDR_WIDTH'(DEV_CAP2_OFF))
                   || (wr_word == ADDR_WIDTH'(DEV_CTL2_OFF))
                   || (wr_word == ADDR_WIDTH'(LINK_CAP2_OFF))
                   || (wr_word == ADDR_WIDTH'(LINK_CTL2_OFF))
                   || (wr_word == ADDR_WIDTH'(SLOT_CAP2_OFF))
                   || (wr_word == ADDR_WIDTH'(SLOT_CTL2_OFF))
                   || (wr_word == ADDR_WIDTH'(SLOT_CTLSTS_OFF));

  // Write response; writes to read-only words complete without effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ----------------------------------------------------------------------
  // Register images; fields not listed read as zero
  // ----------------------------------------------------------------------
  assign dev_ctl2_img = ZERO_WORD
    | (32'(dev_ctl2_ff.ltr_en) << DEVCTL2_LTR_BIT)
    | (32'(dev_ctl2_ff.obff_en) << DEVCTL2_OBFF_LSB);
  assign link_ctl2_img = ZERO_WORD
    | (32'(link_ctl2_ff.target_speed) << LCTL2_SPEED_LSB)
    | (32'(link_ctl2_ff.enter_compliance) << LCTL2_ENTCOMP_BIT)
    | (32'(link_ctl2_ff.hw_autospeed_dis) << LCTL2_HWDIS_BIT)
    | (32'(deemph) << LCTL2_SELDE_BIT)
    | (32'(link_ctl2_ff.tx_margin) << LCTL2_MARGIN_LSB)
    | (32'(link_ctl2_ff.enter_mod_compliance) << LCTL2_MODCOMP_BIT)
    | (32'(link_ctl2_ff.compliance_sos) << LCTL2_SOS_BIT)
    | (32'(link_ctl2_ff.compliance_deemph) << LCTL2_COMPDE_BIT)
    | (32'(deemph) << LSTS2_DELVL_BIT);
  assign slot_sts_img = 32'(dllsc_ff) << SLOTSTS_DLLSC_BIT;

  // Byte-lane merge: only strobed lanes change, then fields are picked out
  assign byte_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                      {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  assign dev_ctl2_merged  = (dev_ctl2_img & ~byte_mask)
                          | (wdata_ff & byte_mask);
  assign link_ctl2_merged = (link_ctl2_img & ~byte_mask)
                          | (wdata_ff & byte_mask);

  // ----------------------------------------------------------------------
  // Control fields; sticky ones survive the conventional reset
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_dev_ctl2  = dev_ctl2_ff;
    nxt_link_ctl2 = link_ctl2_ff;
    if (wr_devctl) begin
      nxt_dev_ctl2.ltr_en  = dev_ctl2_merged[DEVCTL2_LTR_BIT];
      nxt_dev_ctl2.obff_en =
        dev_ctl2_merged[DEVCTL2_OBFF_LSB+:2];
    end
    if (wr_linkctl) begin
      nxt_link_ctl2.target_speed = link_ctl2_merged[LCTL2_SPEED_LSB+:4];
      nxt_link_ctl2.enter_compliance =
        link_ctl2_merged[LCTL2_ENTCOMP_BIT];
      nxt_link_ctl2.hw_autospeed_dis = link_ctl2_merged[LCTL2_HWDIS_BIT];
      nxt_link_ctl2.tx_margin = link_ctl2_merged[LCTL2_MARGIN_LSB+:3];
      nxt_link_ctl2.enter_mod_compliance =
        link_ctl2_merged[LCTL2_MODCOMP_BIT];
      nxt_link_ctl2.compliance_sos = link_ctl2_merged[LCTL2_SOS_BIT];
      nxt_link_ctl2.compliance_deemph =
        link_ctl2_merged[LCTL2_COMPDE_BIT];
    end
    if (!conv_rst_n) begin
      nxt_dev_ctl2                   = DEV_CTL2_RST;
      nxt_link_ctl2.hw_autospeed_dis = 1'b0;
    end
  end

  // Status flag: a change in the same cycle as the clear wins
  assign nxt_dllsc = !conv_rst_n ? 1'b0
    : link_chg
      || (dllsc_ff && !(wr_slotsts && wstrb_ff[3]
                        && wdata_ff[SLOTSTS_DLLSC_BIT]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_ctl2_ff  <= DEV_CTL2_RST;
      link_ctl2_ff <= LINK_CTL2_RST;
      dllsc_ff     <= 1'b0;
    end else begin
      dev_ctl2_ff  <= nxt_dev_ctl2;
      link_ctl2_ff <= nxt_link_ctl2;
      dllsc_ff     <= nxt_dllsc;
    end
  end

  assign dev_ctl2          = dev_ctl2_ff;
  assign link_ctl2         = link_ctl2_ff;
  assign dll_state_changed = dllsc_ff;

  // ----------------------------------------------------------------------
  // Read channel: one read at a time, data registered
  // ----------------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign rd_fire       = s_axi_arvalid && !rvalid_ff;
  assign rd_word       = {s_axi_araddr[ADDR_WIDTH-1:2], 2'h0};

  // Read select; unmapped words answer zero with an error
  always_comb begin
    rd_hit = 1'b1;
    if (rd_word == ADDR_WIDTH'(DEV_CAP2_OFF)) begin
      rd_value = DEV_CAP2_VAL;
    end else if (rd_word == ADDR_WIDTH'(DEV_CTL2_OFF)) begin
      rd_value = dev_ctl2_img;
    end else if (rd_word == ADDR_WIDTH'(LINK_CTL2_OFF)) begin
      rd_value = link_ctl2_img;
    end else if (rd_word == ADDR_WIDTH'(SLOT_CTLSTS_OFF)) begin
      rd_value = slot_sts_img;
    end else if (rd_word == ADDR_WIDTH'(LINK_CAP2_OFF)
              || rd_word == ADDR_WIDTH'(SLOT_CAP2_OFF)
              || rd_word == ADDR_WIDTH'(SLOT_CTL2_OFF)) begin
      rd_value = ZERO_WORD;
    end else begin
      rd_value = ZERO_WORD;
      rd_hit   = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= ZERO_WORD;
      rresp_ff  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_value;
      rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic [ADDR_WIDTH-1:0] chk_raddr_ff;

  // Remembers which word the pending read answers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_raddr_ff <= '0;
    end else if (rd_fire) begin
      chk_raddr_ff <= rd_word;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_devcap_ltr_bit: assert property (
    rd_fire && rd_word == ADDR_WIDTH'(DEV_CAP2_OFF)
    |=> s_axi_rvalid && s_axi_rdata[DEVCAP2_LTR_BIT] == 1'b1)
    else $error("LTR supported bit not read as one");
  a_devcap_obff_field: assert property (
    s_axi_rvalid && chk_raddr_ff == ADDR_WIDTH'(DEV_CAP2_OFF)
    |-> s_axi_rdata[DEVCAP2_OBFF_LSB+:2] == 2'h1
        && s_axi_rdata == DEV_CAP2_VAL)
    else $error("OBFF supported field wrong");
  a_devctl_write_takes: assert property (
    wr_devctl && wstrb_ff[1] && conv_rst_n
    |=> dev_ctl2.ltr_en == $past(wdata_ff[DEVCTL2_LTR_BIT])
        && dev_ctl2.obff_en == $past(wdata_ff[DEVCTL2_OBFF_LSB+:2]))
    else $error("Device control 2 write not applied");
  a_devctl_conv_reset: assert property (
    !conv_rst_n |=> dev_ctl2 == DEV_CTL2_RST ##1 (dev_ctl2 == DEV_CTL2_RST
      || $past(wr_devctl)))
    else $error("Device control 2 not cleared by reset");
  a_deemph_up_port: assert property (
    s_axi_rvalid && !IS_DOWNSTREAM
    && chk_raddr_ff == ADDR_WIDTH'(LINK_CTL2_OFF)
    |-> !s_axi_rdata[LCTL2_SELDE_BIT] && !s_axi_rdata[LSTS2_DELVL_BIT])
    else $error("Upstream de-emphasis bits not zero");
  a_deemph_down_port: assert property (
    s_axi_rvalid && IS_DOWNSTREAM
    && chk_raddr_ff == ADDR_WIDTH'(LINK_CTL2_OFF)
    |-> s_axi_rdata[LCTL2_SELDE_BIT] && s_axi_rdata[LSTS2_DELVL_BIT])
    else $error("Downstream de-emphasis bits not one");
  a_dllsc_set_wins: assert property (
    link_chg && conv_rst_n |=> dll_state_changed)
    else $error("Link-active change did not set status");
  a_dllsc_one_clears: assert property (
    dll_state_changed && wr_slotsts && wstrb_ff[3]
    && wdata_ff[SLOTSTS_DLLSC_BIT] && !link_chg
    |=> !dll_state_changed)
    else $error("Write one did not clear status");
  a_dllsc_zero_keeps: assert property (
    dll_state_changed && conv_rst_n
    && !(wr_slotsts && wstrb_ff[3] && wdata_ff[SLOTSTS_DLLSC_BIT])
    |=> dll_state_changed)
    else $error("Status lost without a clearing write");
  a_zero_words_read: assert property (
    s_axi_rvalid && (chk_raddr_ff == ADDR_WIDTH'(LINK_CAP2_OFF)
      || chk_raddr_ff == ADDR_WIDTH'(SLOT_CAP2_OFF)
      || chk_raddr_ff == ADDR_WIDTH'(SLOT_CTL2_OFF))
    |-> s_axi_rdata == ZERO_WORD && s_axi_rresp == RESP_OKAY)
    else $error("Unimplemented word not zero");
  a_devctl_rsvd_zero: assert property (
    s_axi_rvalid && chk_raddr_ff == ADDR_WIDTH'(DEV_CTL2_OFF)
    |-> (s_axi_rdata & 32'hFFFF_9BFF) == ZERO_WORD)
    else $error("Reserved device control 2 bits not zero");

  c_devctl_write: cover property (wr_devctl && wstrb_ff[1]);
  c_linkctl_read: cover property (
    rd_fire && rd_word == ADDR_WIDTH'(LINK_CTL2_OFF) ##1 s_axi_rvalid);
  c_dllsc_set_clear: cover property (
    link_chg ##[1:20] (wr_slotsts && wdata_ff[SLOTSTS_DLLSC_BIT]));
  c_unmapped_write: cover property (wr_fire && !wr_hit);

endmodule // cap2_regs

// ==== verification/cfg_host.sv ====
// Host model: AXI4-Lite master issuing configuration accesses
`timescale 1ns/1ps
module cfg_host (
  input  wire logic        aclk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // Idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end

  // Address and data offered together; each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Ready held up until the data word comes back
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // cfg_host

// ==== verification/pcie_cap2_config_regs_tb_top.sv ====
// Testbench top for the second-generation capability register bank
`timescale 1ns/1ps
module pcie_cap2_config_regs_tb_top
  import cap2_regs_pkg::*;
;
  logic         aclk, aresetn, conv_rst_n, dl_link_active;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rdata_dn, dat;
  logic [3:0]   s_axi_wstrb;
  logic [2:0]   s_axi_awprot, s_axi_arprot;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
  logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic         s_axi_rvalid, s_axi_rready, dll_state_changed;
  dev_ctl2_type dev_ctl2;
  link_ctl2_type link_ctl2;
  int           err_count = 0;
  int           checks = 0;

  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [1:0]  e;
    logic [31:0] up;
    logic [31:0] dn;
  } row_type;
  row_type rows [12];

  // ----------------------------------------------------------------------
  // Upstream bank, downstream twin and host
  // ----------------------------------------------------------------------
  cap2_regs DUT (.aclk, .aresetn, .conv_rst_n, .dl_link_active,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dev_ctl2,
    .link_ctl2, .dll_state_changed);
  // Twin sees the same traffic; only its read data is watched
  cap2_regs #(.IS_DOWNSTREAM(1'b1)) DUT_DN (.aclk, .aresetn,
    .conv_rst_n, .dl_link_active, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready(), .s_axi_rdata(rdata_dn), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready, .dev_ctl2(), .link_ctl2(),
    .dll_state_changed());
  cfg_host host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // ----------------------------------------------------------------------
  // Clock, compare, verdict, watchdog
  // ----------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {aresetn, dl_link_active, s_axi_awprot, s_axi_arprot} = '0;
    conv_rst_n = 1'b1;
    // Unstrobed rows read reset values without disturbing them
    rows = '{
      '{8'hE4, 32'hFFFFFFFF, 4'h0, 2'h0, 32'h40800, 32'h40800},
      '{8'hE8, 32'hFFFFFFFF, 4'h0, 2'h0, 32'h0, 32'h0},
      '{8'hF0, 32'hFFFFFFFF, 4'h0, 2'h0, 32'h2, 32'h10042},
      '{8'hD8, 32'hFFFFFFFF, 4'hF, 2'h0, 32'h0, 32'h0},
      '{8'hE8, 32'hFFFFFFFF, 4'hF, 2'h0, 32'h6400, 32'h6400},
      '{8'hE8, 32'h0, 4'h1, 2'h0, 32'h6400, 32'h6400},
      '{8'hE8, 32'h0, 4'h2, 2'h0, 32'h0, 32'h0},
      '{8'hF0, 32'hFFFFFFFF, 4'hF, 2'h0, 32'h1FBF, 32'h11FFF},
      '{8'hEC, 32'hFFFFFFFF, 4'hF, 2'h0, 32'h0, 32'h0},
      '{8'hF4, 32'hFFFFFFFF, 4'hF, 2'h0, 32'h0, 32'h0},
      '{8'hF8, 32'hFFFFFFFF, 4'hF, 2'h0, 32'h0, 32'h0},
      '{8'h40, 32'hFFFFFFFF, 4'hF, 2'h2, 32'h0, 32'h0}};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      host.wr(rows[i].a, rows[i].wd, rows[i].ws, rsp);
      chk({30'h0, rsp}, {30'h0, rows[i].e});
      host.rd(rows[i].a, dat, rsp);
      chk(dat, rows[i].up);
      chk(rdata_dn, rows[i].dn);
      chk({30'h0, rsp}, {30'h0, rows[i].e});
    end
    $display("test table done");
    // Either edge of link-active raises the flag; writing zero keeps it
    @(posedge aclk);
    dl_link_active <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({31'h0, dll_state_changed}, 32'h1);
    host.wr(8'hD8, 32'h0, 4'hF, rsp);
    host.rd(8'hD8, dat, rsp);
    chk(dat, 32'h0100_0000);
    host.wr(8'hD8, 32'h0100_0000, 4'hF, rsp);
    host.rd(8'hD8, dat, rsp);
    chk(dat, 32'h0);
    @(posedge aclk);
    dl_link_active <= 1'b0;
    repeat (8) @(posedge aclk);
    chk({31'h0, dll_state_changed}, 32'h1);
    $display("test link change done");
    // Port reset clears enables and flag, sticky link fields survive
    host.wr(8'hE8, 32'hFFFFFFFF, 4'hF, rsp);
    chk({29'h0, dev_ctl2}, 32'h7);
    @(posedge aclk);
    conv_rst_n <= 1'b0;
    @(posedge aclk);
    conv_rst_n <= 1'b1;
    @(posedge aclk);
    chk({29'h0, dev_ctl2}, 32'h0);
    chk({31'h0, dll_state_changed}, 32'h0);
    host.rd(8'hF0, dat, rsp);
    chk(dat, 32'h1F9F);
    chk({20'h0, link_ctl2}, 32'hFDF);
    $display("test port reset done");
    // Full reset in mid-run also clears the sticky fields
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    host.rd(8'hF0, dat, rsp);
    chk(dat, 32'h2);
    chk({20'h0, link_ctl2}, {20'h0, LINK_CTL2_RST});
    $display("test full reset done");
    wrap_up();
  end
endmodule // pcie_cap2_config_regs_tb_top
